/* rtl/hpim_top.sv */
`timescale 1ns/1ps
module hpim_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // On-chip CPU access
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [15:0] cpu_wdata,
    output logic      [15:0] cpu_rdata,
    // Host port access
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic        host_status_rd,
    input  wire logic [15:0] host_addr,
    input  wire logic [15:0] host_port_data_bus_in,
    output logic      [15:0] host_port_data_bus_out,
    output logic             host_mem_cycle,
    output logic             host_port_irq_pin,
    // Serial engine interrupt sources
    input  wire logic        frame_start_irq_one,
    input  wire logic        frame_start_irq_two,
    input  wire logic        transfer_done_one,
    input  wire logic        transfer_done_two,
    input  wire logic        bus_reset_one,
    input  wire logic        bus_reset_two,
    input  wire logic        bus_resume_one,
    input  wire logic        bus_resume_two,
    input  wire logic        bus_supply_irq,
    input  wire logic        otg_identity_irq,
    // OTG pins
    input  wire logic        otg_identity_pin,
    input  wire logic        bus_supply_above,
    // Mailbox interrupt enables
    input  wire logic        mbx_rx_full_en,
    input  wire logic        mbx_tx_empty_en,
    // Interrupts toward the CPU
    output logic             cpu_frame_start_one,
    output logic             cpu_frame_start_two,
    output logic             cpu_transfer_done_one,
    output logic             cpu_transfer_done_two,
    output logic             cpu_bus_reset_one,
    output logic             cpu_bus_reset_two,
    output logic             cpu_bus_resume_one,
    output logic             cpu_bus_resume_two,
    output logic             cpu_bus_supply,
    output logic             cpu_otg_identity,
    output logic             cpu_mbx_rx_full,
    output logic             cpu_mbx_tx_empty
);
    logic [15:0] irq_routing_select;
    logic [15:0] shared_mailbox;
    logic        doorbell_flag_one;
    logic        doorbell_flag_two;
    logic        mbx_in_flag;
    logic        mbx_out_flag;
    logic        mbx_tx_empty_flag;
    logic        bus_supply_flag;
    logic        otg_identity_flag;
    logic        byte_swap;
    logic [15:0] host_wdata;
    logic [15:0] host_status;
    logic [15:0] routed_to_host;

    function automatic logic hit(input logic strobe, input logic [15:0] addr, input logic [15:0] target);
        hit = strobe && (addr == target);
    endfunction

    function automatic logic [15:0] swap_bytes(input logic [15:0] d, input logic en);
        swap_bytes = en ? {d[7:0], d[15:8]} : d;
    endfunction

    hpim_sync u_sync_id (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (otg_identity_pin),
        .sync_out (otg_identity_flag)
    );

    hpim_sync u_sync_supply (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (bus_supply_above),
        .sync_out (bus_supply_flag)
    );

    // A mismatched pair is an illegal setting; it is treated as no swap so the bus stays straight.
    assign byte_swap = irq_routing_select[hpim_pkg::RT_SWAP_HIGH] &&
                       irq_routing_select[hpim_pkg::RT_SWAP_LOW];
    assign host_wdata = swap_bytes(host_port_data_bus_in, byte_swap);

    // The routing register is writable only from the host port.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_routing_select <= hpim_pkg::ROUTING_RESET;
        end else if (hit(host_wr, host_addr, hpim_pkg::ADDR_ROUTING)) begin
            irq_routing_select <= host_wdata;
        end
    end

    // Doorbells: a set in the same cycle as a host read wins over the clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doorbell_flag_one <= 1'b0;
        end else if (hit(cpu_wr, cpu_addr, hpim_pkg::ADDR_DOORBELL_ONE)) begin
            doorbell_flag_one <= 1'b1;
        end else if (hit(host_rd, host_addr, hpim_pkg::ADDR_DOORBELL_ONE)) begin
            doorbell_flag_one <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doorbell_flag_two <= 1'b0;
        end else if (hit(cpu_wr, cpu_addr, hpim_pkg::ADDR_DOORBELL_TWO)) begin
            doorbell_flag_two <= 1'b1;
        end else if (hit(host_rd, host_addr, hpim_pkg::ADDR_DOORBELL_TWO)) begin
            doorbell_flag_two <= 1'b0;
        end
    end

    // Mailbox data: on a collision the CPU word is stored and the host word is dropped.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shared_mailbox <= hpim_pkg::MAILBOX_RESET;
        end else if (hit(cpu_wr, cpu_addr, hpim_pkg::ADDR_MAILBOX)) begin
            shared_mailbox <= cpu_wdata;
        end else if (hit(host_wr, host_addr, hpim_pkg::ADDR_MAILBOX)) begin
            shared_mailbox <= host_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mbx_in_flag <= 1'b0;
        end else if (hit(host_wr, host_addr, hpim_pkg::ADDR_MAILBOX)) begin
            mbx_in_flag <= 1'b1;
        end else if (hit(cpu_rd, cpu_addr, hpim_pkg::ADDR_MAILBOX)) begin
            mbx_in_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mbx_out_flag <= 1'b0;
        end else if (hit(cpu_wr, cpu_addr, hpim_pkg::ADDR_MAILBOX)) begin
            mbx_out_flag <= 1'b1;
        end else if (hit(host_rd, host_addr, hpim_pkg::ADDR_MAILBOX)) begin
            mbx_out_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mbx_tx_empty_flag <= 1'b0;
        end else if (hit(host_rd, host_addr, hpim_pkg::ADDR_MAILBOX)) begin
            mbx_tx_empty_flag <= 1'b1;
        end else if (hit(cpu_wr, cpu_addr, hpim_pkg::ADDR_MAILBOX)) begin
            mbx_tx_empty_flag <= 1'b0;
        end
    end

    // The enable gates only the output, so enabling late still reports an earlier event.
    assign cpu_mbx_rx_full = mbx_in_flag && mbx_rx_full_en;
    assign cpu_mbx_tx_empty = mbx_tx_empty_flag && mbx_tx_empty_en;

    // Frame-start may go to both sides; clearing the source is left to one side's software.
    assign cpu_frame_start_two = frame_start_irq_two &&
                                 irq_routing_select[hpim_pkg::RT_SOF2_CPU];
    assign cpu_frame_start_one = frame_start_irq_one &&
                                 irq_routing_select[hpim_pkg::RT_SOF1_CPU];
    assign cpu_otg_identity = otg_identity_irq && !irq_routing_select[hpim_pkg::RT_ID_HOST];
    assign cpu_bus_supply = bus_supply_irq && !irq_routing_select[hpim_pkg::RT_SUPPLY_HOST];
    assign cpu_bus_reset_two = bus_reset_two && !irq_routing_select[hpim_pkg::RT_BUS_RESET_TWO_HOST];
    assign cpu_bus_reset_one = bus_reset_one && !irq_routing_select[hpim_pkg::RT_BUS_RESET_ONE_HOST];
    assign cpu_bus_resume_two = bus_resume_two && !irq_routing_select[hpim_pkg::RT_BUS_RESUME_TWO_HOST];
    assign cpu_bus_resume_one = bus_resume_one && !irq_routing_select[hpim_pkg::RT_BUS_RESUME_ONE_HOST];
    assign cpu_transfer_done_two = transfer_done_two && !irq_routing_select[hpim_pkg::RT_TRANSFER_DONE_TWO_HOST];
    assign cpu_transfer_done_one = transfer_done_one && !irq_routing_select[hpim_pkg::RT_TRANSFER_DONE_ONE_HOST];

    always_comb begin
        routed_to_host = hpim_pkg::DATA_ZERO;
        routed_to_host[0] = otg_identity_irq && irq_routing_select[hpim_pkg::RT_ID_HOST];
        routed_to_host[1] = frame_start_irq_two && irq_routing_select[hpim_pkg::RT_SOF2_HOST];
        routed_to_host[2] = frame_start_irq_one && irq_routing_select[hpim_pkg::RT_SOF1_HOST];
        routed_to_host[3] = bus_reset_two && irq_routing_select[hpim_pkg::RT_BUS_RESET_TWO_HOST];
        routed_to_host[4] = bus_reset_one && irq_routing_select[hpim_pkg::RT_BUS_RESET_ONE_HOST];
        routed_to_host[5] = bus_resume_two && irq_routing_select[hpim_pkg::RT_BUS_RESUME_TWO_HOST];
        routed_to_host[6] = bus_resume_one && irq_routing_select[hpim_pkg::RT_BUS_RESUME_ONE_HOST];
        routed_to_host[7] = transfer_done_two && irq_routing_select[hpim_pkg::RT_TRANSFER_DONE_TWO_HOST];
        routed_to_host[8] = transfer_done_one && irq_routing_select[hpim_pkg::RT_TRANSFER_DONE_ONE_HOST];
        routed_to_host[9] = bus_supply_irq && irq_routing_select[hpim_pkg::RT_SUPPLY_HOST];
    end

    assign host_port_irq_pin = (|routed_to_host) || doorbell_flag_one || doorbell_flag_two ||
                               mbx_out_flag;

    always_comb begin
        host_status = hpim_pkg::DATA_ZERO;
        // The supply flag is only meaningful once software has let the supply settle for 10 us.
        host_status[hpim_pkg::ST_SUPPLY] = bus_supply_flag;
        host_status[hpim_pkg::ST_ID] = otg_identity_flag;
        host_status[hpim_pkg::ST_SOF2] = frame_start_irq_two;
        host_status[hpim_pkg::ST_SOF1] = frame_start_irq_one;
        host_status[hpim_pkg::ST_BUS_RESET_TWO] = bus_reset_two;
        host_status[hpim_pkg::ST_MBX_IN] = mbx_in_flag;
        host_status[hpim_pkg::ST_BUS_RESUME_TWO] = bus_resume_two;
        host_status[hpim_pkg::ST_BUS_RESUME_ONE] = bus_resume_one;
        host_status[hpim_pkg::ST_DB2] = doorbell_flag_two;
        host_status[hpim_pkg::ST_DB1] = doorbell_flag_one;
        host_status[hpim_pkg::ST_TRANSFER_DONE_TWO] = transfer_done_two;
        host_status[hpim_pkg::ST_TRANSFER_DONE_ONE] = transfer_done_one;
        host_status[hpim_pkg::ST_BUS_RESET_ONE] = bus_reset_one;
        host_status[hpim_pkg::ST_MBX_OUT] = mbx_out_flag;
    end

    // Status polling bypasses the memory path, so it never steals a CPU or DMA cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_mem_cycle <= 1'b0;
        end else begin
            host_mem_cycle <= (host_rd || host_wr) && !host_status_rd;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_port_data_bus_out <= hpim_pkg::DATA_ZERO;
        end else if (host_status_rd) begin
            host_port_data_bus_out <= swap_bytes(host_status, byte_swap);
        end else if (hit(host_rd, host_addr, hpim_pkg::ADDR_MAILBOX)) begin
            host_port_data_bus_out <= swap_bytes(shared_mailbox, byte_swap);
        end else if (hit(host_rd, host_addr, hpim_pkg::ADDR_ROUTING)) begin
            host_port_data_bus_out <= swap_bytes(irq_routing_select, byte_swap);
        end else if (host_rd) begin
            host_port_data_bus_out <= hpim_pkg::DATA_ZERO;
        end
    end

    // The CPU has no path to the status port; routing reads back read-only on this side.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= hpim_pkg::DATA_ZERO;
        end else if (hit(cpu_rd, cpu_addr, hpim_pkg::ADDR_MAILBOX)) begin
            cpu_rdata <= shared_mailbox;
        end else if (hit(cpu_rd, cpu_addr, hpim_pkg::ADDR_ROUTING)) begin
            cpu_rdata <= irq_routing_select;
        end else if (cpu_rd) begin
            cpu_rdata <= hpim_pkg::DATA_ZERO;
        end
    end
endmodule

/* rtl/hpim_pkg.sv */
package hpim_pkg;
    // Word addresses seen by the CPU and the host port.
    localparam logic [15:0] ADDR_ROUTING = 16'h0142;
    localparam logic [15:0] ADDR_DOORBELL_ONE = 16'h0144;
    localparam logic [15:0] ADDR_DOORBELL_TWO = 16'h0148;
    localparam logic [15:0] ADDR_MAILBOX = 16'hC0C6;

    // Reset values.
    localparam logic [15:0] ROUTING_RESET = 16'h1400;
    localparam logic [15:0] MAILBOX_RESET = 16'h0000;
    localparam logic [15:0] DATA_ZERO = 16'h0000;

    // Routing register field positions.
    localparam int RT_SUPPLY_HOST = 15;
    localparam int RT_ID_HOST = 14;
    localparam int RT_SOF2_HOST = 13;
    localparam int RT_SOF2_CPU = 12;
    localparam int RT_SOF1_HOST = 11;
    localparam int RT_SOF1_CPU = 10;
    localparam int RT_BUS_RESET_TWO_HOST = 9;
    localparam int RT_SWAP_HIGH = 8;
    localparam int RT_BUS_RESUME_TWO_HOST = 7;
    localparam int RT_BUS_RESUME_ONE_HOST = 6;
    localparam int RT_TRANSFER_DONE_TWO_HOST = 3;
    localparam int RT_TRANSFER_DONE_ONE_HOST = 2;
    localparam int RT_BUS_RESET_ONE_HOST = 1;
    localparam int RT_SWAP_LOW = 0;

    // Host status port field positions.
    localparam int ST_SUPPLY = 15;
    localparam int ST_ID = 14;
    localparam int ST_SOF2 = 12;
    localparam int ST_SOF1 = 10;
    localparam int ST_BUS_RESET_TWO = 9;
    localparam int ST_MBX_IN = 8;
    localparam int ST_BUS_RESUME_TWO = 7;
    localparam int ST_BUS_RESUME_ONE = 6;
    localparam int ST_DB2 = 5;
    localparam int ST_DB1 = 4;
    localparam int ST_TRANSFER_DONE_TWO = 3;
    localparam int ST_TRANSFER_DONE_ONE = 2;
    localparam int ST_BUS_RESET_ONE = 1;
    localparam int ST_MBX_OUT = 0;
endpackage

/* rtl/hpim_sync.sv */
`timescale 1ns/1ps
module hpim_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Asynchronous level in, filtered level out
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change is accepted only once the last two stages agree, which hides a single-cycle glitch.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out <= 1'b0;
        end else if (stage2 == stage3) begin
            sync_out <= stage3;
        end
    end
endmodule

/* sim/hpim_host_model.sv */
`timescale 1ns/1ps
module hpim_host_model (
    // Clock
    input  wire logic        clk,
    // Answers from the device
    input  wire logic [15:0] host_port_data_bus_out,
    input  wire logic        host_mem_cycle,
    // Requests to the device
    output logic             host_wr,
    output logic             host_rd,
    output logic             host_status_rd,
    output logic      [15:0] host_addr,
    output logic      [15:0] host_port_data_bus_in
);
    initial begin
        {host_wr, host_rd, host_status_rd} = 3'h0;
        host_addr = 16'h0000;
        host_port_data_bus_in = 16'hFFFF;
    end
    // One strobe for one rising edge; the answer is taken at the falling edge after it.
    // The host never clears frame-start sources, the CPU side owns that clear.
    task automatic access(input logic [2:0] kind, input logic [15:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic m);
        @(negedge clk);
        {host_wr, host_rd, host_status_rd} = kind;
        host_addr = a;
        host_port_data_bus_in = d;
        @(negedge clk);
        q = host_port_data_bus_out;
        m = host_mem_cycle;
        {host_wr, host_rd, host_status_rd} = 3'h0;
        // Idle lines show the inverse, so a stale word never passes for a fresh one.
        host_port_data_bus_in = ~d;
        host_addr = ~a;
    endtask
endmodule

/* sim/hpim_top_chk.sv */
`timescale 1ns/1ps
module hpim_top_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Requests
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic [15:0] cpu_addr,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic        host_status_rd,
    input wire logic [15:0] host_addr,
    input wire logic        mbx_rx_full_en,
    input wire logic        mbx_tx_empty_en,
    // Answers
    input wire logic        host_mem_cycle,
    input wire logic        host_port_irq_pin,
    input wire logic        cpu_mbx_rx_full,
    input wire logic        cpu_mbx_tx_empty,
    // Sample interrupt routes
    input wire logic        transfer_done_one,
    input wire logic        cpu_transfer_done_one,
    input wire logic        bus_reset_two,
    input wire logic        cpu_bus_reset_two,
    input wire logic        frame_start_irq_one,
    input wire logic        cpu_frame_start_one
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic cpu_put, cpu_take, host_put, host_take;
    assign cpu_put = cpu_wr && cpu_addr == hpim_pkg::ADDR_MAILBOX;
    assign cpu_take = cpu_rd && cpu_addr == hpim_pkg::ADDR_MAILBOX;
    assign host_put = host_wr && host_addr == hpim_pkg::ADDR_MAILBOX;
    assign host_take = host_rd && host_addr == hpim_pkg::ADDR_MAILBOX;
    sequence s_rx_arm; host_put ##1 mbx_rx_full_en; endsequence
    sequence s_tx_arm; host_take ##1 mbx_tx_empty_en; endsequence
    property p_mbx_out; cpu_put |=> host_port_irq_pin; endproperty
    a_mbx_out: assert property (p_mbx_out) else $error("pin low after mailbox write");
    property p_bell; cpu_wr && (cpu_addr == hpim_pkg::ADDR_DOORBELL_ONE ||
        cpu_addr == hpim_pkg::ADDR_DOORBELL_TWO) |=> host_port_irq_pin; endproperty
    a_bell: assert property (p_bell) else $error("pin low after doorbell");
    property p_rx_set; s_rx_arm |-> cpu_mbx_rx_full; endproperty
    a_rx_set: assert property (p_rx_set) else $error("rx full missing");
    property p_rx_clr; cpu_take && !host_put |=> !cpu_mbx_rx_full; endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("rx full stuck");
    property p_tx_set; s_tx_arm |-> cpu_mbx_tx_empty; endproperty
    a_tx_set: assert property (p_tx_set) else $error("tx empty missing");
    property p_tx_clr; cpu_put && !host_take |=> !cpu_mbx_tx_empty; endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("tx empty stuck");
    property p_mem; (host_rd || host_wr) && !host_status_rd |=> host_mem_cycle; endproperty
    a_mem: assert property (p_mem) else $error("memory cycle missing");
    property p_quiet; host_status_rd |=> !host_mem_cycle; endproperty
    a_quiet: assert property (p_quiet) else $error("status read made a cycle");
    property p_away; (transfer_done_one && !cpu_transfer_done_one) ||
        (bus_reset_two && !cpu_bus_reset_two) |-> host_port_irq_pin; endproperty
    a_away: assert property (p_away) else $error("routed source lost");
    property p_sof; cpu_frame_start_one |-> frame_start_irq_one; endproperty
    a_sof: assert property (p_sof) else $error("frame start without source");
endmodule

/* sim/hpim_top_bench.sv */
`timescale 1ns/1ps
module hpim_top_bench;
    localparam int rb[10] = '{1, 2, 3, 6, 7, 9, 11, 13, 14, 15};
    localparam int sb[8] = '{1, 2, 3, 6, 7, 9, 10, 12};
    logic        clk, rst_n, cpu_wr, cpu_rd, host_wr, host_rd, host_status_rd, hm;
    logic        host_mem_cycle, host_port_irq_pin, otg_identity_pin, bus_supply_above;
    logic        mbx_rx_full_en, mbx_tx_empty_en, cpu_mbx_rx_full, cpu_mbx_tx_empty;
    logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, host_addr, host_port_data_bus_in;
    logic [15:0] host_port_data_bus_out, hq;
    logic [9:0]  src, co;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    hpim_top hpim_top_inst (
        .clk, .rst_n, .cpu_wr, .cpu_rd, .cpu_addr, .cpu_wdata, .cpu_rdata,
        .host_wr, .host_rd, .host_status_rd, .host_addr, .host_port_data_bus_in,
        .host_port_data_bus_out, .host_mem_cycle, .host_port_irq_pin,
        .bus_supply_irq(src[9]), .otg_identity_irq(src[8]), .frame_start_irq_two(src[7]),
        .frame_start_irq_one(src[6]), .bus_reset_two(src[5]), .bus_resume_two(src[4]),
        .bus_resume_one(src[3]), .transfer_done_two(src[2]), .transfer_done_one(src[1]),
        .bus_reset_one(src[0]), .otg_identity_pin, .bus_supply_above, .mbx_rx_full_en,
        .mbx_tx_empty_en, .cpu_bus_supply(co[9]), .cpu_otg_identity(co[8]),
        .cpu_frame_start_two(co[7]), .cpu_frame_start_one(co[6]), .cpu_bus_reset_two(co[5]),
        .cpu_bus_resume_two(co[4]), .cpu_bus_resume_one(co[3]), .cpu_transfer_done_two(co[2]),
        .cpu_transfer_done_one(co[1]), .cpu_bus_reset_one(co[0]), .cpu_mbx_rx_full, .cpu_mbx_tx_empty
    );
    hpim_host_model hpim_host_model_inst (
        .clk, .host_port_data_bus_out, .host_mem_cycle, .host_wr, .host_rd, .host_status_rd,
        .host_addr, .host_port_data_bus_in
    );
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cpu_acc(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {w, r, a, d};
        @(negedge clk);
        {cpu_wr, cpu_rd} = 2'h0;
    endtask
    task automatic host_acc(input logic [2:0] kind, input logic [15:0] a, input logic [15:0] d);
        hpim_host_model_inst.access(kind, a, d, hq, hm);
    endtask
    task automatic pin(input logic exp);
        chk("host pin", {15'h0000, exp}, {15'h0000, host_port_irq_pin});
    endtask
    task automatic t_reset();
        cpu_acc(1'b1, 1'b0, hpim_pkg::ADDR_ROUTING, 16'hFFFF);
        cpu_acc(1'b0, 1'b1, hpim_pkg::ADDR_ROUTING, 16'h0000);
        chk("routing", hpim_pkg::ROUTING_RESET, cpu_rdata);
        host_acc(3'h1, 16'h0000, 16'h0000);
        chk("status", 16'h0000, hq);
        chk("mem cycle", 16'h0000, {15'h0000, hm});
        host_acc(3'h2, 16'h0100, 16'h0000);
        chk("mem cycle", 16'h0001, {15'h0000, hm});
    endtask
    task automatic t_route();
        for (int i = 0; i < 10; i++) begin
            host_acc(3'h4, hpim_pkg::ADDR_ROUTING, 16'h0001 << rb[i]);
            src = 10'h001 << i;
            host_acc(3'h1, 16'h0000, 16'h0000);
            chk("cpu irq", 16'h0000, {6'h00, co});
            pin(1'b1);
            chk("status", (i < 8) ? 16'h0001 << sb[i] : 16'h0000, hq);
            host_acc(3'h4, hpim_pkg::ADDR_ROUTING, hpim_pkg::ROUTING_RESET);
            chk("cpu irq", {6'h00, src}, {6'h00, co});
            pin(1'b0);
            src = 10'h000;
        end
        host_acc(3'h4, hpim_pkg::ADDR_ROUTING, 16'h3000);
        src = 10'h080;
        host_acc(3'h1, 16'h0000, 16'h0000);
        chk("cpu irq", 16'h0080, {6'h00, co});
        pin(1'b1);
        src = 10'h000;
    endtask
    task automatic t_doorbell();
        logic [15:0] a;
        for (int j = 0; j < 2; j++) begin
            a = j ? hpim_pkg::ADDR_DOORBELL_TWO : hpim_pkg::ADDR_DOORBELL_ONE;
            cpu_acc(1'b1, 1'b0, a, 16'h5A5A);
            host_acc(3'h1, 16'h0000, 16'h0000);
            chk("status", 16'h0010 << j, hq);
            pin(1'b1);
            host_acc(3'h2, a, 16'h0000);
            host_acc(3'h1, 16'h0000, 16'h0000);
            chk("status", 16'h0000, hq);
            pin(1'b0);
        end
    endtask
    task automatic t_mailbox();
        host_acc(3'h4, hpim_pkg::ADDR_MAILBOX, 16'hA5C3);
        chk("rx full", 16'h0001, {15'h0000, cpu_mbx_rx_full});
        host_acc(3'h1, 16'h0000, 16'h0000);
        chk("status", 16'h0100, hq);
        cpu_acc(1'b0, 1'b1, hpim_pkg::ADDR_MAILBOX, 16'h0000);
        chk("cpu data", 16'hA5C3, cpu_rdata);
        chk("rx full", 16'h0000, {15'h0000, cpu_mbx_rx_full});
        cpu_acc(1'b1, 1'b0, hpim_pkg::ADDR_MAILBOX, 16'h3C5A);
        pin(1'b1);
        host_acc(3'h1, 16'h0000, 16'h0000);
        chk("status", 16'h0001, hq);
        host_acc(3'h2, hpim_pkg::ADDR_MAILBOX, 16'h0000);
        chk("host data", 16'h3C5A, hq);
        pin(1'b0);
        chk("tx empty", 16'h0001, {15'h0000, cpu_mbx_tx_empty});
        cpu_acc(1'b1, 1'b0, hpim_pkg::ADDR_MAILBOX, 16'h0F0F);
        chk("tx empty", 16'h0000, {15'h0000, cpu_mbx_tx_empty});
        host_acc(3'h2, hpim_pkg::ADDR_MAILBOX, 16'h0000);
        mbx_rx_full_en = 1'b0;
        host_acc(3'h4, hpim_pkg::ADDR_MAILBOX, 16'h0001);
        chk("rx full", 16'h0000, {15'h0000, cpu_mbx_rx_full});
        mbx_rx_full_en = 1'b1;
        cpu_acc(1'b0, 1'b1, hpim_pkg::ADDR_MAILBOX, 16'h0000);
    endtask
    task automatic t_swap();
        // Both swap bits are always written equal.
        host_acc(3'h4, hpim_pkg::ADDR_ROUTING, 16'h0101);
        host_acc(3'h4, hpim_pkg::ADDR_MAILBOX, 16'h1234);
        cpu_acc(1'b0, 1'b1, hpim_pkg::ADDR_MAILBOX, 16'h0000);
        chk("cpu data", 16'h3412, cpu_rdata);
        cpu_acc(1'b1, 1'b0, hpim_pkg::ADDR_MAILBOX, 16'hABCD);
        host_acc(3'h2, hpim_pkg::ADDR_MAILBOX, 16'h0000);
        chk("host data", 16'hCDAB, hq);
        host_acc(3'h4, hpim_pkg::ADDR_ROUTING, 16'h0000);
    endtask
    task automatic t_pins();
        {otg_identity_pin, bus_supply_above} = 2'h3;
        // The supply flag is only sampled after the settle time.
        repeat (1000) @(negedge clk);
        host_acc(3'h1, 16'h0000, 16'h0000);
        chk("status", 16'hC000, hq);
        {otg_identity_pin, bus_supply_above} = 2'h0;
        repeat (8) @(negedge clk);
        host_acc(3'h1, 16'h0000, 16'h0000);
        chk("status", 16'h0000, hq);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        {rst_n, cpu_wr, cpu_rd, cpu_addr, cpu_wdata, src} = '0;
        {otg_identity_pin, bus_supply_above, mbx_rx_full_en, mbx_tx_empty_en} = 4'h3;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_route();
        t_doorbell();
        t_mailbox();
        t_swap();
        t_pins();
        report_and_stop();
    end
endmodule
bind hpim_top hpim_top_chk hpim_top_chk_inst (
    .clk, .rst_n, .cpu_wr, .cpu_rd, .cpu_addr, .host_wr, .host_rd, .host_status_rd, .host_addr,
    .mbx_rx_full_en, .mbx_tx_empty_en, .host_mem_cycle, .host_port_irq_pin, .cpu_mbx_rx_full,
    .cpu_mbx_tx_empty, .transfer_done_one, .cpu_transfer_done_one, .bus_reset_two,
    .cpu_bus_reset_two, .frame_start_irq_one, .cpu_frame_start_one
);
